//--- errlog_pkg.sv
// constants, types and helpers shared by the error log recorder
// assumes one clock domain; every user of it imports the whole package
// Overview of operation
// - the RAM table holds up to 64 records, one record per error
// - when all 64 slots are full, a new error replaces the oldest
// - a record holds error code, two detail bytes and a timestamp
// - fatal errors are also written to the nonvolatile store
// - at startup the nonvolatile records are copied into the RAM table
// - log reads return RAM table records only, never the store directly
// - a clear request made while not busy erases both the RAM table and the store
// - timestamps come from time the host sends periodically
// - with no time ever received, a new record gets timestamp 0
// - host watchdog timeout: code 0x0001, details 0x00 0x00, stored
// - registered slave not joined: code 0x0370, zero details, not stored
// - node errors: first byte unit type, second byte node address
// - unregistered slave appearing: code 0x0372, node details, not stored
// - slave or repeater separated: code 0x0374, node details, not stored
// - stop on communications error: code 0x0375, node details, stored
// - duplicate address or unstable slave: code 0x0376, not stored
// - repeater beyond 2 segments: code 0x0378, node details, not stored
// - illegal interrupt: code 0x0601, first byte 0x00, stored
// - store failure: code 0x0602, read/write and area bytes, stored unless the area is the log area
package errlog_pkg;
    localparam int          LOG_DEPTH   = 64;
    localparam int          IDX_W       = 6;
    localparam int          CNT_W       = 7;
    localparam int          TIME_W      = 32;
    localparam int          REC_W       = 64;
    localparam int          EE_AW       = 7;
    localparam logic [6:0]  CNT_FULL    = 7'h40;
    localparam logic [6:0]  EE_HDR_ADDR = 7'h40;
    // record field positions
    localparam int          REC_CODE_LSB = 48;
    localparam int          REC_D1_LSB   = 40;
    localparam int          REC_D2_LSB   = 32;
    // store header word: record count and write slot
    localparam int          HDR_CNT_LSB  = 0;
    localparam int          HDR_PTR_LSB  = 8;
    localparam logic [15:0] CODE_WDOG    = 16'h0001;
    localparam logic [15:0] CODE_MISSING = 16'h0370;
    localparam logic [15:0] CODE_UNREG   = 16'h0372;
    localparam logic [15:0] CODE_SEPAR   = 16'h0374;
    localparam logic [15:0] CODE_STOP    = 16'h0375;
    localparam logic [15:0] CODE_DUP     = 16'h0376;
    localparam logic [15:0] CODE_REPEAT  = 16'h0378;
    localparam logic [15:0] CODE_IRQ     = 16'h0601;
    localparam logic [15:0] CODE_MEM     = 16'h0602;
    localparam logic [7:0]  UNIT_WORD_IN = 8'h10;
    localparam logic [7:0]  UNIT_WORD_OUT = 8'h20;
    localparam logic [7:0]  UNIT_BIT_IN  = 8'h40;
    localparam logic [7:0]  UNIT_BIT_OUT = 8'h50;
    localparam logic [7:0]  UNIT_REPEAT  = 8'h70;
    localparam logic [7:0]  MEM_READ     = 8'h01;
    localparam logic [7:0]  MEM_WRITE    = 8'h02;
    localparam logic [7:0]  AREA_LOG     = 8'h06;
    localparam logic [7:0]  AREA_IDENT   = 8'h09;
    localparam logic [7:0]  DETAIL_NONE  = 8'h00;

    typedef enum logic [3:0] {
        K_WDOG = 4'h0, K_MISSING = 4'h1, K_UNREG = 4'h2, K_SEPAR = 4'h3,
        K_STOP = 4'h4, K_DUP = 4'h5, K_REPEAT = 4'h6, K_IRQ = 4'h7,
        K_MEM = 4'h8
    } err_kind_t;

    typedef enum logic [5:0] {
        S_BOOT_HDR = 6'h01, S_BOOT_REC = 6'h02, S_IDLE = 6'h04,
        S_EE_REC = 6'h08, S_EE_HDR = 6'h10, S_CLR_HDR = 6'h20
    } seq_state_t;

    function automatic logic [6:0] sat_inc(input logic [6:0] c);
        return (c == CNT_FULL) ? c : 7'(c + 7'h01);
    endfunction
endpackage

//--- error_encoder.sv
// maps an error kind plus its raw details onto code, detail bytes
// and the flag that asks for a nonvolatile copy; purely combinational
`timescale 1ns/1ns
module error_encoder
    import errlog_pkg::*;
(
    input  wire err_kind_t   kind_in,
    input  wire logic [7:0]  unit_in,
    input  wire logic [7:0]  node_in,
    input  wire logic        mem_write_in,
    input  wire logic        mem_log_area_in,
    output logic      [15:0] code_out,
    output logic      [7:0]  d1_out,
    output logic      [7:0]  d2_out,
    output logic             persist_out
);
    wire is_node = kind_in inside {K_UNREG, K_SEPAR, K_STOP, K_DUP,
                                   K_REPEAT};
    wire is_mem  = (kind_in == K_MEM);

    assign code_out =
        (kind_in == K_WDOG)    ? CODE_WDOG :
        (kind_in == K_MISSING) ? CODE_MISSING :
        (kind_in == K_UNREG)   ? CODE_UNREG :
        (kind_in == K_SEPAR)   ? CODE_SEPAR :
        (kind_in == K_STOP)    ? CODE_STOP :
        (kind_in == K_DUP)     ? CODE_DUP :
        (kind_in == K_REPEAT)  ? CODE_REPEAT :
        (kind_in == K_IRQ)     ? CODE_IRQ :
                                 CODE_MEM;
    // unit type and node address pass through for node errors
    assign d1_out = is_node ? unit_in :
                    is_mem  ? (mem_write_in ? MEM_WRITE : MEM_READ)
                            : DETAIL_NONE;
    // the illegal interrupt second byte is undefined; zero is used
    assign d2_out = is_node ? node_in :
                    is_mem  ? (mem_log_area_in ? AREA_LOG : AREA_IDENT)
                            : DETAIL_NONE;
    // a failing log area cannot hold its own failure record
    assign persist_out = (kind_in == K_WDOG) | (kind_in == K_STOP) |
                         (kind_in == K_IRQ) |
                         (is_mem & ~mem_log_area_in);
endmodule // error_encoder

//--- log_ram.sv
// 64-record flip-flop table: one write port, one registered read port
// read of an out-of-range slot is asked for with zero_in and yields 0
`timescale 1ns/1ns
module log_ram
    import errlog_pkg::*;
(
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             we_in,
    input  wire logic [IDX_W-1:0] widx_in,
    input  wire logic [REC_W-1:0] wdata_in,
    input  wire logic             re_in,
    input  wire logic             zero_in,
    input  wire logic [IDX_W-1:0] ridx_in,
    output logic      [REC_W-1:0] rdata_out
);
    logic [REC_W-1:0] mem_q [LOG_DEPTH];
    logic [REC_W-1:0] rdata_q;

    always_ff @(posedge sys_clk_in) begin
        if (we_in) begin
            mem_q[widx_in] <= wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= '0;
        end else if (re_in) begin
            rdata_q <= zero_in ? '0 : mem_q[ridx_in];
        end
    end

    assign rdata_out = rdata_q;
endmodule // log_ram

//--- error_log_recorder.sv
// error log recorder: circular RAM table, fatal copies in a nonvolatile
// store reached through a request/acknowledge port, startup restore
// assumes the store controller and host logic run on sys_clk_in
`timescale 1ns/1ns
module error_log_recorder
    import errlog_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              rst_in,
    input  wire logic              evt_valid_in,
    input  wire err_kind_t         evt_kind_in,
    input  wire logic [7:0]        evt_unit_in,
    input  wire logic [7:0]        evt_node_in,
    input  wire logic              evt_mem_write_in,
    input  wire logic              evt_mem_log_area_in,
    output logic                   evt_ready_out,
    input  wire logic              time_valid_in,
    input  wire logic [TIME_W-1:0] time_in,
    input  wire logic              rd_req_in,
    input  wire logic [IDX_W-1:0]  rd_idx_in,
    output logic                   rd_valid_out,
    output logic      [15:0]       rd_code_out,
    output logic      [7:0]        rd_d1_out,
    output logic      [7:0]        rd_d2_out,
    output logic      [TIME_W-1:0] rd_time_out,
    output logic      [CNT_W-1:0]  log_count_out,
    input  wire logic              clr_req_in,
    output logic                   busy_out,
    output logic                   ee_req_out,
    output logic                   ee_write_out,
    output logic      [EE_AW-1:0]  ee_addr_out,
    output logic      [REC_W-1:0]  ee_wdata_out,
    input  wire logic [REC_W-1:0]  ee_rdata_in,
    input  wire logic              ee_ack_in,
    input  wire logic              ee_fail_in
);
    seq_state_t        state_q, state_d;
    logic [IDX_W-1:0]  wptr_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [IDX_W-1:0]  ee_ptr_q;
    logic [CNT_W-1:0]  ee_cnt_q;
    logic [CNT_W-1:0]  load_idx_q;
    logic [REC_W-1:0]  pend_q;
    logic [TIME_W-1:0] time_q;
    logic              time_seen_q;
    logic              rd_valid_q;
    logic [REC_W-1:0]  rd_rec;

    wire is_idle  = (state_q == S_IDLE);
    wire ee_busy  = ~is_idle;
    wire ee_wr_st = (state_q == S_EE_REC) | (state_q == S_EE_HDR) |
                    (state_q == S_CLR_HDR);
    wire ee_done  = ee_busy & ee_ack_in;
    wire ee_ok    = ee_done & ~ee_fail_in;
    // a failed store access becomes a log entry of its own
    wire int_err  = ee_done & ee_fail_in;

    // clear wins over a new event in the same cycle
    assign evt_ready_out = is_idle & ~clr_req_in;
    wire evt_fire = evt_valid_in & evt_ready_out;
    wire clr_fire = clr_req_in & is_idle;

    err_kind_t   enc_kind;
    logic [15:0] enc_code;
    logic [7:0]  enc_d1;
    logic [7:0]  enc_d2;
    logic        enc_persist;

    assign enc_kind = int_err ? K_MEM : evt_kind_in;

    error_encoder u_enc (
        .kind_in         (enc_kind),
        .unit_in         (evt_unit_in),
        .node_in         (evt_node_in),
        .mem_write_in    (int_err ? ee_wr_st : evt_mem_write_in),
        .mem_log_area_in (int_err | evt_mem_log_area_in),
        .code_out        (enc_code),
        .d1_out          (enc_d1),
        .d2_out          (enc_d2),
        .persist_out     (enc_persist)
    );

    // without any host time the stamp stays at zero
    wire [TIME_W-1:0] stamp = time_seen_q ? time_q : '0;
    wire [REC_W-1:0]  new_rec = {enc_code, enc_d1, enc_d2, stamp};

    wire boot_load = (state_q == S_BOOT_REC) & ee_ok;
    wire new_we    = evt_fire | int_err;
    wire ram_we    = new_we | boot_load;
    wire [REC_W-1:0] ram_wdata = boot_load ? ee_rdata_in : new_rec;
    wire persist_go = evt_fire & enc_persist;

    // oldest slot sits cnt entries behind the write slot
    wire [IDX_W-1:0] rd_phys =
        IDX_W'(wptr_q - cnt_q[IDX_W-1:0] + rd_idx_in);
    wire rd_out_of_range = ({1'b0, rd_idx_in} >= cnt_q);
    wire [IDX_W-1:0] boot_addr =
        IDX_W'(ee_ptr_q - ee_cnt_q[IDX_W-1:0] + load_idx_q[IDX_W-1:0]);

    log_ram u_ram (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .we_in      (ram_we),
        .widx_in    (wptr_q),
        .wdata_in   (ram_wdata),
        .re_in      (rd_req_in),
        .zero_in    (rd_out_of_range),
        .ridx_in    (rd_phys),
        .rdata_out  (rd_rec)
    );

    // header fields read back at startup, count capped at full
    wire [CNT_W-1:0] hdr_cnt_raw = ee_rdata_in[HDR_CNT_LSB +: CNT_W];
    wire [CNT_W-1:0] hdr_cnt = (hdr_cnt_raw > CNT_FULL) ? CNT_FULL
                                                        : hdr_cnt_raw;
    wire [IDX_W-1:0] hdr_ptr = ee_rdata_in[HDR_PTR_LSB +: IDX_W];
    wire [REC_W-1:0] hdr_word =
        (REC_W'(ee_cnt_q) << HDR_CNT_LSB) |
        (REC_W'(ee_ptr_q) << HDR_PTR_LSB);
    wire [CNT_W-1:0] load_next = CNT_W'(load_idx_q + 7'h01);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_BOOT_HDR: begin
                if (ee_done) begin
                    state_d = (ee_fail_in || hdr_cnt == '0) ? S_IDLE
                                                           : S_BOOT_REC;
                end
            end
            S_BOOT_REC: begin
                if (ee_done && (ee_fail_in || load_next == ee_cnt_q)) begin
                    state_d = S_IDLE;
                end
            end
            S_IDLE: begin
                if (clr_fire) begin
                    state_d = S_CLR_HDR;
                end else if (persist_go) begin
                    state_d = S_EE_REC;
                end
            end
            S_EE_REC: begin
                if (ee_done) begin
                    state_d = ee_fail_in ? S_IDLE : S_EE_HDR;
                end
            end
            S_EE_HDR, S_CLR_HDR: begin
                if (ee_done) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= S_BOOT_HDR;
        end else begin
            state_q <= state_d;
        end
    end

    // RAM table pointers; once full the write slot is the oldest record
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_q <= '0;
            cnt_q  <= '0;
        end else if (clr_fire) begin
            wptr_q <= '0;
            cnt_q  <= '0;
        end else if (ram_we) begin
            wptr_q <= IDX_W'(wptr_q + 6'h01);
            cnt_q  <= sat_inc(cnt_q);
        end
    end

    // store bookkeeping mirrors what its header word holds
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ee_ptr_q   <= '0;
            ee_cnt_q   <= '0;
            load_idx_q <= '0;
        end else if (clr_fire) begin
            ee_ptr_q   <= '0;
            ee_cnt_q   <= '0;
        end else if (state_q == S_BOOT_HDR && ee_ok) begin
            ee_ptr_q   <= hdr_ptr;
            ee_cnt_q   <= hdr_cnt;
            load_idx_q <= '0;
        end else if (boot_load) begin
            load_idx_q <= load_next;
        end else if (state_q == S_EE_REC && ee_ok) begin
            ee_ptr_q   <= IDX_W'(ee_ptr_q + 6'h01);
            ee_cnt_q   <= sat_inc(ee_cnt_q);
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_q <= '0;
        end else if (persist_go) begin
            pend_q <= new_rec;
        end
    end

    // host time holds until the next update; a late host keeps old time
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            time_q      <= '0;
            time_seen_q <= 1'b0;
        end else if (time_valid_in) begin
            time_q      <= time_in;
            time_seen_q <= 1'b1;
        end
    end

    // reads touch the RAM table only and never wait on the store
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_req_in;
        end
    end

    assign rd_valid_out  = rd_valid_q;
    assign rd_code_out   = rd_rec[REC_CODE_LSB +: 16];
    assign rd_d1_out     = rd_rec[REC_D1_LSB +: 8];
    assign rd_d2_out     = rd_rec[REC_D2_LSB +: 8];
    assign rd_time_out   = rd_rec[TIME_W-1:0];
    assign log_count_out = cnt_q;
    assign busy_out      = ee_busy;

    assign ee_req_out   = ee_busy;
    assign ee_write_out = ee_wr_st;
    assign ee_addr_out  = (state_q == S_BOOT_REC) ? {1'b0, boot_addr} :
                          (state_q == S_EE_REC)   ? {1'b0, ee_ptr_q}
                                                  : EE_HDR_ADDR;
    assign ee_wdata_out = (state_q == S_EE_REC) ? pend_q :
                          (state_q == S_EE_HDR) ? hdr_word : '0;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    chk_count_cap: assert property (cnt_q <= CNT_FULL)
        else $error("record count above table size");
    chk_full_wrap: assert property (
        (cnt_q == CNT_FULL && ram_we && !clr_fire) |=>
            (cnt_q == CNT_FULL && wptr_q == IDX_W'($past(wptr_q) + 6'h01)))
        else $error("full table did not overwrite oldest");
    chk_record_fields: assert property (
        evt_fire |-> (ram_we && ram_wdata[REC_CODE_LSB +: 16] == enc_code
                      && ram_wdata[TIME_W-1:0] == stamp))
        else $error("record fields not assembled");
    chk_persist_copy: assert property (
        persist_go |=> (state_q == S_EE_REC && ee_req_out && ee_write_out
                        && ee_wdata_out == $past(new_rec)))
        else $error("fatal error not sent to store");
    chk_boot_start: assert property (
        $past(rst_in) |-> (state_q == S_BOOT_HDR && ee_req_out &&
                           !ee_write_out && ee_addr_out == EE_HDR_ADDR))
        else $error("startup did not read store header");
    chk_read_answer: assert property (
        rd_req_in |=> rd_valid_out)
        else $error("read not answered next cycle");
    chk_clear_both: assert property (
        clr_fire |=> (cnt_q == '0 && state_q == S_CLR_HDR &&
                      ee_write_out && ee_wdata_out == '0))
        else $error("clear missed a store");
    chk_time_take: assert property (
        time_valid_in |=> (time_seen_q && time_q == $past(time_in)))
        else $error("host time not captured");
    chk_stamp_zero: assert property (
        (new_we && !time_seen_q) |-> ram_wdata[TIME_W-1:0] == '0)
        else $error("stamp not zero before host time");
    chk_wdog_code: assert property (
        (evt_fire && evt_kind_in == K_WDOG) |->
            (ram_wdata[REC_D2_LSB +: 32] == {CODE_WDOG, 16'h0000}
             && enc_persist))
        else $error("watchdog record wrong");
    chk_local_only: assert property (
        (evt_fire && !enc_persist) |=> is_idle)
        else $error("non fatal error went to store");
    chk_node_detail: assert property (
        (evt_fire && evt_kind_in inside {K_UNREG, K_SEPAR, K_DUP}) |->
            (enc_d1 == evt_unit_in && enc_d2 == evt_node_in && !enc_persist))
        else $error("node detail bytes wrong");
    chk_mem_fail: assert property (
        (int_err && state_q == S_EE_REC) |-> (ram_we && !persist_go &&
            enc_code == CODE_MEM && enc_d1 == MEM_WRITE) ##1 is_idle)
        else $error("store failure not logged locally");
    chk_store_hold: assert property (
        (ee_req_out && !ee_ack_in) |=> (ee_req_out && $stable(ee_addr_out)
            && $stable(ee_write_out) && $stable(ee_wdata_out)))
        else $error("store request changed before acknowledge");
    chk_store_hdr: assert property (
        (state_q == S_EE_REC && ee_ok) |=> (state_q == S_EE_HDR &&
            ee_write_out && ee_addr_out == EE_HDR_ADDR))
        else $error("store header not written after record");
    chk_boot_copy: assert property (
        boot_load |=> cnt_q == 7'($past(cnt_q) + 7'h01))
        else $error("restored record not counted");
    chk_clear_done: assert property (
        (state_q == S_CLR_HDR && ee_ok) |=> (is_idle && cnt_q == '0 &&
            ee_cnt_q == '0))
        else $error("clear did not empty both stores");
    chk_range_zero: assert property (
        (rd_req_in && rd_out_of_range) |=> (rd_code_out == 16'h0000 &&
            rd_time_out == '0))
        else $error("read beyond count not zero");

    cov_wrap: cover property (cnt_q == CNT_FULL && evt_fire);
    cov_boot_load: cover property (boot_load ##1 is_idle);
    cov_persist: cover property (persist_go ##[1:20] state_q == S_EE_HDR);
    cov_clear: cover property (clr_fire ##[1:20] is_idle);
    cov_store_fail: cover property (int_err && state_q == S_EE_REC);
endmodule // error_log_recorder

//--- nv_store_model.sv
// behavioural nonvolatile store on the recorder's request/acknowledge port
// assumes one clock; 65 words, slot 0x40 is the header; starts erased
`timescale 1ns/1ns
module nv_store_model (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        req_in,
    input  wire logic        write_in,
    input  wire logic [6:0]  addr_in,
    input  wire logic [63:0] wdata_in,
    input  wire logic [3:0]  lat_in,
    input  wire logic        fail_next_in,
    output logic      [63:0] rdata_out,
    output logic             ack_out,
    output logic             fail_out
);
    logic [63:0] mem [0:64];
    logic [3:0]  cnt_q;

    initial begin
        for (int i = 0; i < 65; i++) begin
            mem[i] = 64'h0;
        end
    end

    // requests seen during reset are ignored; idle data never looks valid
    always @(posedge sys_clk_in) begin
        if (rst_in || ack_out) begin
            ack_out   <= 1'b0;
            fail_out  <= 1'b0;
            cnt_q     <= 4'h0;
            rdata_out <= ~rdata_out;
        end else if (req_in && cnt_q >= lat_in) begin
            ack_out   <= 1'b1;
            fail_out  <= fail_next_in;
            rdata_out <= mem[addr_in];
            if (write_in && !fail_next_in) begin
                mem[addr_in] <= wdata_in;
            end
        end else if (req_in) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // nv_store_model

//--- test_error_log_recorder.sv
// self-checking bench for the error log recorder with a store model
// assumes 100 MHz clock; inputs change on the falling edge only
`timescale 1ns/1ns
module test_error_log_recorder;
    import errlog_pkg::*;
    typedef struct {
        err_kind_t k; logic [7:0] u, n; logic mw, la;
        logic [15:0] code; logic [7:0] d1, d2; logic p;
    } row_t;
    row_t rows [10] = '{
        '{K_WDOG, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0001, 8'h00, 8'h00, 1'b1},
        '{K_MISSING, 8'h10, 8'h33, 1'b0, 1'b0, 16'h0370, 8'h00, 8'h00, 1'b0},
        '{K_UNREG, 8'h10, 8'h05, 1'b0, 1'b0, 16'h0372, 8'h10, 8'h05, 1'b0},
        '{K_SEPAR, 8'h70, 8'h07, 1'b0, 1'b0, 16'h0374, 8'h70, 8'h07, 1'b0},
        '{K_STOP, 8'h20, 8'h09, 1'b0, 1'b0, 16'h0375, 8'h20, 8'h09, 1'b1},
        '{K_DUP, 8'h40, 8'h0A, 1'b0, 1'b0, 16'h0376, 8'h40, 8'h0A, 1'b0},
        '{K_REPEAT, 8'h50, 8'h0B, 1'b0, 1'b0, 16'h0378, 8'h50, 8'h0B, 1'b0},
        '{K_IRQ, 8'h55, 8'h00, 1'b0, 1'b0, 16'h0601, 8'h00, 8'h00, 1'b1},
        '{K_MEM, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0602, 8'h01, 8'h09, 1'b1},
        '{K_MEM, 8'h00, 8'h00, 1'b1, 1'b1, 16'h0602, 8'h02, 8'h06, 1'b0}};
    localparam logic [31:0] T0 = 32'h12345678;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, evt_valid_in = 1'b0;
    logic mw = 1'b0, la = 1'b0, time_valid_in = 1'b0, rd_req_in = 1'b0;
    logic clr_req_in = 1'b0, fail_next = 1'b0;
    err_kind_t kind = K_WDOG;
    logic [7:0] unit = 8'h00, node = 8'h00;
    logic [31:0] time_in = 32'h0;
    logic [5:0] rd_idx_in = 6'h0;
    logic [3:0] lat = 4'h0;
    logic evt_ready_out, rd_valid_out, busy_out, ee_req_out, ee_write_out;
    logic ee_ack_in, ee_fail_in;
    logic [15:0] rd_code_out;
    logic [7:0] rd_d1_out, rd_d2_out;
    logic [31:0] rd_time_out;
    logic [6:0] log_count_out, ee_addr_out;
    logic [63:0] ee_wdata_out, ee_rdata_in;
    int bad_count = 0, checked = 0, cycles = 0;

    error_log_recorder i_error_log_recorder (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .evt_valid_in(evt_valid_in), .evt_kind_in(kind),
        .evt_unit_in(unit), .evt_node_in(node), .evt_mem_write_in(mw),
        .evt_mem_log_area_in(la), .evt_ready_out(evt_ready_out),
        .time_valid_in(time_valid_in), .time_in(time_in),
        .rd_req_in(rd_req_in), .rd_idx_in(rd_idx_in),
        .rd_valid_out(rd_valid_out), .rd_code_out(rd_code_out),
        .rd_d1_out(rd_d1_out), .rd_d2_out(rd_d2_out),
        .rd_time_out(rd_time_out), .log_count_out(log_count_out),
        .clr_req_in(clr_req_in), .busy_out(busy_out),
        .ee_req_out(ee_req_out), .ee_write_out(ee_write_out),
        .ee_addr_out(ee_addr_out), .ee_wdata_out(ee_wdata_out),
        .ee_rdata_in(ee_rdata_in), .ee_ack_in(ee_ack_in),
        .ee_fail_in(ee_fail_in));
    nv_store_model i_nv_store_model (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .req_in(ee_req_out), .write_in(ee_write_out),
        .addr_in(ee_addr_out), .wdata_in(ee_wdata_out), .lat_in(lat),
        .fail_next_in(fail_next), .rdata_out(ee_rdata_in),
        .ack_out(ee_ack_in), .fail_out(ee_fail_in));

    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic finish_test();
        $display("tests done: %0d checked, %0d bad", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("unexpected at %0t: run did not complete", $time);
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
            bad_count++;
        end
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 400 && busy_out !== 1'b0; i++)
            @(negedge sys_clk_in);
    endtask

    task automatic do_reset();
        @(negedge sys_clk_in);
        rst_in = 1'b1;
        repeat (8) @(negedge sys_clk_in);
        chk({rd_valid_out, log_count_out}, 8'h00, "reset outputs");
        rst_in = 1'b0;
        wait_idle();
    endtask

    task automatic send(input err_kind_t k, input logic [7:0] u, n,
                        input logic w, a, input logic p);
        @(negedge sys_clk_in);
        kind = k;
        {unit, node, mw, la, evt_valid_in} = {u, n, w, a, 1'b1};
        @(posedge sys_clk_in);
        for (int i = 0; i < 400 && evt_ready_out !== 1'b1; i++)
            @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        evt_valid_in = 1'b0;
        chk(busy_out, p, "store copy started");
        wait_idle();
    endtask

    task automatic read_rec(input logic [5:0] idx, input logic [63:0] exp);
        @(negedge sys_clk_in);
        {rd_req_in, rd_idx_in} = {1'b1, idx};
        @(negedge sys_clk_in);
        rd_req_in = 1'b0;
        chk(rd_valid_out, 1'b1, "read valid");
        chk({rd_code_out, rd_d1_out, rd_d2_out, rd_time_out}, exp, "record");
    endtask

    initial begin
        do_reset();
        chk(log_count_out, 7'h00, "empty after first boot");
        send(K_DUP, 8'h40, 8'h01, 1'b0, 1'b0, 1'b0);
        read_rec(6'h00, {16'h0376, 8'h40, 8'h01, 32'h0});
        @(negedge sys_clk_in);
        {time_valid_in, time_in} = {1'b1, T0};
        @(negedge sys_clk_in);
        time_valid_in = 1'b0;
        lat = 4'h3;
        foreach (rows[r]) begin
            send(rows[r].k, rows[r].u, rows[r].n, rows[r].mw, rows[r].la,
                 rows[r].p);
            read_rec(6'(r + 1), {rows[r].code, rows[r].d1, rows[r].d2,
                     T0});
        end
        chk(log_count_out, 7'd11, "count after table");
        $display("test code table done");
        lat = 4'h0;
        for (int i = 0; i < 60; i++)
            send(K_DUP, 8'h40, 8'(i), 1'b0, 1'b0, 1'b0);
        chk(log_count_out, 7'h40, "count capped");
        read_rec(6'h00, {16'h0378, 8'h50, 8'h0B, T0});
        read_rec(6'h3F, {16'h0376, 8'h40, 8'h3B, T0});
        $display("test wrap done");
        fail_next = 1'b1;
        send(K_WDOG, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        fail_next = 1'b0;
        read_rec(6'h3E, {16'h0001, 8'h00, 8'h00, T0});
        read_rec(6'h3F, {16'h0602, 8'h02, 8'h06, T0});
        $display("test store failure done");
        do_reset();
        chk(log_count_out, 7'h04, "restored count");
        read_rec(6'h00, {16'h0001, 8'h00, 8'h00, T0});
        read_rec(6'h03, {16'h0602, 8'h01, 8'h09, T0});
        read_rec(6'h04, 64'h0);
        $display("test restore done");
        @(negedge sys_clk_in);
        clr_req_in = 1'b1;
        @(negedge sys_clk_in);
        clr_req_in = 1'b0;
        chk(log_count_out, 7'h00, "cleared count");
        wait_idle();
        read_rec(6'h00, 64'h0);
        do_reset();
        chk(log_count_out, 7'h00, "store cleared too");
        $display("test clear done");
        finish_test();
    end
endmodule // test_error_log_recorder
